// ---- src/rcdc_map.vh ----
// Register map, reset values and timing constants for the reset and clock-domain controller
`ifndef RCDC_MAP_VH
`define RCDC_MAP_VH
// Register byte offsets
`define RCDC_CTRL_OFS 8'h00
`define RCDC_STAT_OFS 8'h04
`define RCDC_CAUSE_OFS 8'h08
`define RCDC_STRAP_OFS 8'h0C
`define RCDC_HSIO_OFS 8'h10
// Control fields
`define RCDC_CTRL_HOST_RESET_AT_POWERUP_ENABLE_BIT 0
`define RCDC_CTRL_XTALOFF_BIT 1
`define RCDC_CTRL_R2EN_BIT 2
`define RCDC_CTRL_R2SEL_BIT 3
`define RCDC_CTRL_CLK_LSB 4
`define RCDC_CTRL_CLK_MSB 7
`define RCDC_CTRL_RESET 32'h0000_0000
// Host config register fields
`define RCDC_HSIO_SWRST_BIT 1
`define RCDC_HSIO_LOCK_BIT 7
`define RCDC_HSIO_RESET 8'h00
// Clock generator default code (4 MHz)
`define RCDC_CLKSEL_DEFAULT 4'h4
// Reset cause codes
`define RCDC_CAUSE_POR 4'h1
`define RCDC_CAUSE_WDT 4'h2
`define RCDC_CAUSE_DBG 4'h4
`define RCDC_CAUSE_WARM 4'h8
// Internal reset delay in ns, and its cycle count at 10 ns
`define RCDC_IRST_NS 2000
`define RCDC_CLK_NS 10
`define RCDC_IRST_CYC ((`RCDC_IRST_NS + `RCDC_CLK_NS - 1) / `RCDC_CLK_NS)
`define RCDC_CNT_W 16
// LPC sync codes for long wait and ready
`define RCDC_SYNC_LWAIT 4'h6
`define RCDC_SYNC_READY 4'h0
`endif

// ---- src/rcdc_sync.v ----
// Two-flop synchroniser with asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module rcdc_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire resetn,
	input wire [W-1:0] asyncIn,
	output reg [W-1:0] syncOut
);
	reg [W-1:0] meta_q;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= {W{1'b0}};
			syncOut <= {W{1'b0}};
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- src/rcdc_top.v ----
// Reset sequencer and clock-domain control with AXI4-Lite registers
//
// How it works
// RL1: retained-rail reset holds while rail not good; clears retained registers.
// RL2: power-up reset ends a fixed internal delay after clocks are stable.
// RL3: host accesses during reset get long-wait sync until reset ends.
// RL4: with host-reset-at-powerup set, keyboard host reset asserts until reset done; the bit is cleared during power-up, so only later resets assert it.
// RL5: power-up enables 32 KHz crystal, default clock, reloads supply-retained registers.
// RL6: power-up floats strap pins, enables pull-downs, then samples straps.
// RL7: power-up also resets test-access logic, wake control, port C bit zero, warm actions.
// RL8: watchdog and debugger resets repeat power-up actions, same length, no strap resample.
// RL9: those keep test-access logic; reset clock gen; port C bit zero only on watchdog.
// RL10: warm reset on primary reset falling edge; power-up reset wins.
// RL11: warm reset aborts core, discards results, drops interrupts, clears edge latch.
// RL12: warm reset deasserts bus strobes and selects, floats address and data buses.
// RL13: warm reset: Active mode, defaults except retained regs, debug reset, straps kept.
// RL14: host domain stays in reset while primary reset input is low.
// RL15: flash setting enables secondary host reset on one of two pins, as GPIO interrupt.
// RL16: host hardware reset while primary low, or secondary low with host power up.
// RL17: host hardware reset idles LPC engine, clears config and shared-memory registers.
// RL18: writing 1 to bit 1 of host config register starts host software reset.
// RL19: lock bits survive software reset; only hardware reset unlocks.
// RL20: power-up sets clock generator to 4 MHz code; firmware may change it.
// RL21: host supplies LPC clock at most 33 MHz, possibly slowed.
// RL22: 32 KHz reference enabled at power-up, kept running while retained rail is up.
// RL23: every reset source releases synchronously; only resetn asserts asynchronously, the others are synchronised to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "rcdc_map.vh"
module rcdc_top #(
	parameter IRST_CYC = `RCDC_IRST_CYC
) (
	input wire clk_sys,
	input wire resetn,
	input wire retainGood,
	input wire supplyPorN,
	input wire clocksStable,
	input wire watchdogReq,
	input wire debugResetReq,
	input wire primaryResetN,
	input wire secondaryResetPinA,
	input wire secondaryResetPinB,
	input wire hostPowerOn,
	input wire flashR2Enable,
	input wire flashR2Select,
	input wire lpcBusClockPin,
	input wire lpcAccessReq,
	input wire [2:0] strapIn,
	output wire [2:0] strapOut,
	output wire [2:0] strapOe,
	output wire [2:0] strapPullDown,
	output reg [3:0] lpcSync,
	output reg lpcSyncValid,
	output wire keyboardHostResetOut,
	output wire coreResetN,
	output wire coreAbort,
	output wire tapResetN,
	output wire wakeCtrlResetN,
	output wire retainedResetN,
	output wire portCBitZeroResetN,
	output wire hostHwResetN,
	output wire hostSwResetPulse,
	output wire lpcEngineIdle,
	output wire busCtrlDeassert,
	output wire busFloat,
	output wire coreActiveMode,
	output wire secondaryResetIrq,
	output reg xtalEnable,
	output reg [3:0] clockGenSel,
	output wire lpcClockSeen,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	wire [10:0] syncV;
	rcdc_sync #(.W(11)) uSync (
		.clk(clk_sys),
		.resetn(resetn),
		.asyncIn({retainGood, supplyPorN, clocksStable, watchdogReq, debugResetReq, primaryResetN,
			secondaryResetPinA, secondaryResetPinB, hostPowerOn, lpcBusClockPin, lpcAccessReq}),
		.syncOut(syncV)
	);
	wire retGoodS = syncV[10];
	wire supplyPorNS = syncV[9];
	wire clkStableS = syncV[8];
	wire wdReqS = syncV[7];
	wire dbgReqS = syncV[6];
	wire prim_s = syncV[5];
	wire r2aS = syncV[4];
	wire r2bS = syncV[3];
	wire hostPwrS = syncV[2];
	wire lclkS = syncV[1];
	wire lpcReqS = syncV[0];
	wire [2:0] strapS;
	rcdc_sync #(.W(3)) uSyncStrap (
		.clk(clk_sys),
		.resetn(resetn),
		.asyncIn(strapIn),
		.syncOut(strapS)
	);

	// ----------------------------------------
	// Reset sequencer state machine
	// ----------------------------------------
	localparam [3:0] ST_RUN = 4'b0001;
	localparam [3:0] ST_WAITCLK = 4'b0010;
	localparam [3:0] ST_DELAY = 4'b0100;
	localparam [3:0] ST_WARM = 4'b1000;

	reg [3:0] state_q;
	reg [`RCDC_CNT_W-1:0] cnt_q;
	reg porPhase_q;
	reg tapReset_q;
	reg pc0Reset_q;
	reg [3:0] cause_q;
	reg primPrev_q;
	reg [2:0] strap_q;
	reg strapFloat_q;
	reg lclkPrev_q;
	reg lclkSeen_q;

	wire primFall = primPrev_q & ~prim_s;
	wire [`RCDC_CNT_W-1:0] irstLast = IRST_CYC[`RCDC_CNT_W-1:0] - 16'h0001;
	wire inReset = ~state_q[0];
	wire porStart = ~supplyPorNS;

	// Supply power-up reset is asserted by resetn (async) and by the synchronised
	// power-good input, so the whole machine releases only on clk_sys.
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_WAITCLK;
			cnt_q <= {`RCDC_CNT_W{1'b0}};
			porPhase_q <= 1'b1;
			tapReset_q <= 1'b1;
			pc0Reset_q <= 1'b1;
			cause_q <= `RCDC_CAUSE_POR;
			primPrev_q <= 1'b1;
			strapFloat_q <= 1'b1;
			strap_q <= 3'h0;
		end else begin
			primPrev_q <= prim_s;
			if (porStart) begin
				// Power-up wins over any coincident warm or watchdog event
				state_q <= ST_WAITCLK; // RL10
				cnt_q <= {`RCDC_CNT_W{1'b0}};
				porPhase_q <= 1'b1;
				tapReset_q <= 1'b1; // RL7
				pc0Reset_q <= 1'b1; // RL7
				strapFloat_q <= 1'b1; // RL6
				cause_q <= `RCDC_CAUSE_POR;
			end else if (wdReqS || dbgReqS) begin
				// Same duration as power-up, straps and test-access logic untouched
				state_q <= ST_DELAY; // RL8
				cnt_q <= {`RCDC_CNT_W{1'b0}};
				porPhase_q <= 1'b0;
				pc0Reset_q <= wdReqS; // RL9
				cause_q <= wdReqS ? `RCDC_CAUSE_WDT : `RCDC_CAUSE_DBG;
			end else if (primFall && state_q[0]) begin
				state_q <= ST_WARM; // RL10
				cause_q <= `RCDC_CAUSE_WARM;
			end else begin
				case (state_q)
					ST_WAITCLK: begin
						if (clkStableS) begin
							state_q <= ST_DELAY;
						end
					end
					ST_DELAY: begin
						if (cnt_q >= irstLast) begin
							state_q <= ST_RUN; // RL2
							if (strapFloat_q) begin
								strap_q <= strapS; // RL6
							end
							strapFloat_q <= 1'b0;
							porPhase_q <= 1'b0;
							tapReset_q <= 1'b0;
							pc0Reset_q <= 1'b0;
						end else begin
							cnt_q <= cnt_q + 16'h0001;
						end
					end
					ST_WARM: begin
						state_q <= ST_RUN;
					end
					ST_RUN: begin
						cnt_q <= {`RCDC_CNT_W{1'b0}};
					end
					default: begin
						state_q <= ST_WAITCLK;
					end
				endcase
			end
		end
	end

	// Strap pins are released to pull-downs during power-up; sampled at its end.
	assign strapOut = 3'h0; // RL6
	assign strapOe = 3'h0; // RL6
	assign strapPullDown = {3{strapFloat_q}}; // RL6

	// ----------------------------------------
	// Reset outputs
	// ----------------------------------------
	assign coreResetN = ~inReset; // RL23
	assign coreAbort = inReset; // RL11
	assign busCtrlDeassert = inReset; // RL12
	assign busFloat = inReset; // RL12
	assign coreActiveMode = ~inReset; // RL13
	assign tapResetN = ~tapReset_q; // RL7
	assign wakeCtrlResetN = ~(inReset & (porPhase_q | cause_q != `RCDC_CAUSE_WARM)); // RL7
	assign portCBitZeroResetN = ~pc0Reset_q; // RL9
	assign retainedResetN = retGoodS; // RL1

	// ----------------------------------------
	// Host domain reset
	// ----------------------------------------
	reg [31:0] ctrl_q;
	reg [7:0] hsio_q;
	reg hostSw_q;
	wire r2En = flashR2Enable; // RL15
	wire r2Pin = flashR2Select ? r2bS : r2aS; // RL15
	wire r2Active = r2En & ~r2Pin & hostPwrS; // RL16
	wire hostHw = ~prim_s | r2Active | porPhase_q; // RL14
	assign hostHwResetN = ~hostHw; // RL16
	assign lpcEngineIdle = hostHw; // RL17
	assign hostSwResetPulse = hostSw_q; // RL18
	assign secondaryResetIrq = r2En & ~r2Pin; // RL15
	assign keyboardHostResetOut = ctrl_q[`RCDC_CTRL_HOST_RESET_AT_POWERUP_ENABLE_BIT] & inReset; // RL4

	// ----------------------------------------
	// LPC stall and link clock observation
	// ----------------------------------------
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lpcSync <= `RCDC_SYNC_READY;
			lpcSyncValid <= 1'b0;
			lclkPrev_q <= 1'b0;
			lclkSeen_q <= 1'b0;
		end else begin
			lclkPrev_q <= lclkS;
			if (lclkS & ~lclkPrev_q) begin
				lclkSeen_q <= 1'b1;
			end
			lpcSyncValid <= lpcReqS;
			lpcSync <= inReset ? `RCDC_SYNC_LWAIT : `RCDC_SYNC_READY; // RL3
		end
	end
	assign lpcClockSeen = lclkSeen_q;

	// ----------------------------------------
	// AXI4-Lite register slave
	// ----------------------------------------
	reg awHeld_q;
	reg wHeld_q;
	reg [7:0] awAddr_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
	assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;

	function [31:0] mergeBytes;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			mergeBytes = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					mergeBytes[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	function known;
		input [7:0] a;
		begin
			known = (a == `RCDC_CTRL_OFS) || (a == `RCDC_STAT_OFS) || (a == `RCDC_CAUSE_OFS) ||
				(a == `RCDC_STRAP_OFS) || (a == `RCDC_HSIO_OFS);
		end
	endfunction

	wire [31:0] ctrlNew = mergeBytes(ctrl_q, wData_q, wStrb_q);
	wire [31:0] hsioNew = mergeBytes({24'h0, hsio_q}, wData_q, wStrb_q);

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0000_0000;
			ctrl_q <= `RCDC_CTRL_RESET;
			hsio_q <= `RCDC_HSIO_RESET;
			hostSw_q <= 1'b0;
			xtalEnable <= 1'b1;
			clockGenSel <= `RCDC_CLKSEL_DEFAULT;
		end else begin
			hostSw_q <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known(awAddr_q) ? 2'h0 : 2'h2;
				if (awAddr_q == `RCDC_CTRL_OFS) begin
					ctrl_q <= ctrlNew;
				end
				if (awAddr_q == `RCDC_HSIO_OFS) begin
					// Lock bit can only be set here; only hardware reset clears it
					hsio_q[`RCDC_HSIO_LOCK_BIT] <= hsio_q[`RCDC_HSIO_LOCK_BIT] | hsioNew[7]; // RL19
					if (!hsio_q[`RCDC_HSIO_LOCK_BIT]) begin
						hsio_q[6:2] <= hsioNew[6:2];
						hsio_q[0] <= hsioNew[0];
					end
					if (hsioNew[`RCDC_HSIO_SWRST_BIT] && wStrb_q[0]) begin
						hostSw_q <= 1'b1; // RL18
						if (!hsio_q[`RCDC_HSIO_LOCK_BIT]) begin
							hsio_q[6:2] <= 5'h00; // RL18
							hsio_q[0] <= 1'b0;
						end
					end
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= known(s_axi_araddr) ? 2'h0 : 2'h2;
				case (s_axi_araddr)
					`RCDC_CTRL_OFS: s_axi_rdata <= ctrl_q;
					`RCDC_STAT_OFS: s_axi_rdata <= {23'h0, lclkSeen_q, hostHw, retGoodS, xtalEnable,
						porPhase_q, state_q};
					`RCDC_CAUSE_OFS: s_axi_rdata <= {28'h0, cause_q};
					`RCDC_STRAP_OFS: s_axi_rdata <= {29'h0, strap_q};
					`RCDC_HSIO_OFS: s_axi_rdata <= {24'h0, hsio_q};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (porPhase_q) begin
				// Supply-retained defaults, clock default, crystal on, host regs cleared
				ctrl_q <= `RCDC_CTRL_RESET; // RL5
				xtalEnable <= 1'b1; // RL22
				clockGenSel <= `RCDC_CLKSEL_DEFAULT; // RL20
				hsio_q <= `RCDC_HSIO_RESET; // RL17
			end else begin
				if (inReset && cause_q != `RCDC_CAUSE_WARM) begin
					clockGenSel <= `RCDC_CLKSEL_DEFAULT; // RL9
				end else if (doWrite && awAddr_q == `RCDC_CTRL_OFS) begin
					clockGenSel <= ctrlNew[`RCDC_CTRL_CLK_MSB:`RCDC_CTRL_CLK_LSB];
					// Crystal stays on while retained rail is up
					xtalEnable <= ~ctrlNew[`RCDC_CTRL_XTALOFF_BIT] | retGoodS; // RL22
				end
				if (hostHw) begin
					hsio_q <= `RCDC_HSIO_RESET; // RL17
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/rcdc_props.sv ----
// Port-level assertions for the reset and clock-domain controller
`timescale 1ns/1ps
`default_nettype none
`include "rcdc_map.vh"
module rcdc_props #(
	parameter int IRST_CYC = 200
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic retainGood,
	input wire logic primaryResetN,
	input wire logic coreResetN,
	input wire logic [3:0] lpcSync,
	input wire logic keyboardHostResetOut,
	input wire logic [2:0] strapOe,
	input wire logic [2:0] strapPullDown,
	input wire logic hostHwResetN,
	input wire logic lpcEngineIdle,
	input wire logic hostSwResetPulse,
	input wire logic xtalEnable,
	input wire logic retainedResetN,
	input wire logic coreAbort,
	input wire logic busFloat,
	input wire logic busCtrlDeassert,
	input wire logic [3:0] clockGenSel
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Length of the current core reset; short warm pulses are filtered below
	logic [15:0] lowCnt_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			lowCnt_q <= 16'h0000;
		else if (coreResetN)
			lowCnt_q <= 16'h0000;
		else
			lowCnt_q <= lowCnt_q + 16'h0001;
	end
	sequence s_held_reset;
		!coreResetN [*3];
	endsequence
	sequence s_running;
		(coreResetN && hostHwResetN) [*3];
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_sync_wait; s_held_reset |-> lpcSync == 4'h6; endproperty
	property p_sync_ready; s_running |-> lpcSync == 4'h0; endproperty
	property p_keyboard_host_reset_out; keyboardHostResetOut |-> !coreResetN; endproperty
	property p_strap; strapPullDown != 3'h0 |-> !coreResetN && strapOe == 3'h0; endproperty
	property p_host_hold; !primaryResetN [*3] |-> !hostHwResetN; endproperty
	property p_lpc_idle; !hostHwResetN |-> lpcEngineIdle; endproperty
	property p_sw_pulse; hostSwResetPulse |=> !hostSwResetPulse; endproperty
	property p_xtal; s_held_reset |-> xtalEnable; endproperty
	property p_retain; !retainGood [*3] |-> !retainedResetN; endproperty
	property p_warm_acts; !coreResetN |-> coreAbort && busFloat && busCtrlDeassert; endproperty
	property p_clk_default; s_held_reset ##1 coreResetN |-> clockGenSel == `RCDC_CLKSEL_DEFAULT; endproperty
	property p_len; $rose(coreResetN) && lowCnt_q > 16'h0003 |-> lowCnt_q >= IRST_CYC; endproperty
	a_sync_wait: assert property (p_sync_wait) else $error("no long wait during reset");
	a_sync_ready: assert property (p_sync_ready) else $error("sync not ready after reset");
	a_keyboard_host_reset_out: assert property (p_keyboard_host_reset_out) else $error("host reset out of reset");
	a_strap: assert property (p_strap) else $error("strap pins not floated");
	a_host_hold: assert property (p_host_hold) else $error("host domain left reset");
	a_lpc_idle: assert property (p_lpc_idle) else $error("lpc engine busy in reset");
	a_sw_pulse: assert property (p_sw_pulse) else $error("software reset pulse too long");
	a_xtal: assert property (p_xtal) else $error("crystal off in reset");
	a_retain: assert property (p_retain) else $error("retained reset missing");
	a_warm_acts: assert property (p_warm_acts) else $error("bus not parked in reset");
	a_clk_default: assert property (p_clk_default) else $error("clock select not default");
	a_len: assert property (p_len) else $error("reset too short");
endmodule
bind rcdc_top rcdc_props #(.IRST_CYC(IRST_CYC)) u_props (.clk_sys(clk_sys), .resetn(resetn),
	.retainGood(retainGood), .primaryResetN(primaryResetN), .coreResetN(coreResetN), .lpcSync(lpcSync),
	.keyboardHostResetOut(keyboardHostResetOut), .strapOe(strapOe), .strapPullDown(strapPullDown),
	.hostHwResetN(hostHwResetN), .lpcEngineIdle(lpcEngineIdle), .hostSwResetPulse(hostSwResetPulse),
	.xtalEnable(xtalEnable), .retainedResetN(retainedResetN), .coreAbort(coreAbort), .busFloat(busFloat),
	.busCtrlDeassert(busCtrlDeassert), .clockGenSel(clockGenSel));
`default_nettype wire

// ---- verif/rcdc_host_model.sv ----
// Host-side model of the link: clocks frames and sits out long-wait syncs
`timescale 1ns/1ps
`default_nettype none
`include "rcdc_map.vh"
module rcdc_host_model (
	input wire logic frameReq,
	input wire logic [3:0] lpcSync,
	output logic lpcClk,
	output logic accessReq
);
	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	// 8 MHz link clock, well under the ceiling; it stands low between frames
	initial begin
		lpcClk = 1'b0;
		accessReq = 1'b0;
		forever begin
			// Level wait, so a request raised soon after the last frame is not missed
			wait (frameReq);
			accessReq = 1'b1;
			while (frameReq || lpcSync == `RCDC_SYNC_LWAIT) begin
				#62.5 lpcClk = ~lpcClk;
			end
			lpcClk = 1'b0;
			accessReq = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the reset and clock-domain controller
`timescale 1ns/1ps
`default_nettype none
`include "rcdc_map.vh"
module tb_top;
	localparam int IRST = 8;
	logic clk_sys, resetn, retainGood, supplyPorN, clocksStable, watchdogReq, debugResetReq, primaryResetN;
	logic secondaryResetPinA, secondaryResetPinB, hostPowerOn, flashR2Enable, flashR2Select, frameReq;
	logic swSeen = 1'b0;
	logic lpcBusClockPin, lpcAccessReq, lpcSyncValid, keyboardHostResetOut, coreResetN, coreAbort, tapResetN;
	logic wakeCtrlResetN, retainedResetN, portCBitZeroResetN, hostHwResetN, hostSwResetPulse, lpcEngineIdle;
	logic busCtrlDeassert, busFloat, coreActiveMode, secondaryResetIrq, xtalEnable, lpcClockSeen;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [2:0] strapIn, strapOut, strapOe, strapPullDown;
	logic [3:0] lpcSync, clockGenSel, s_axi_wstrb;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int c;
	rcdc_top #(.IRST_CYC(IRST)) u_dut (.*);
	rcdc_host_model u_host (.frameReq(frameReq), .lpcSync(lpcSync), .lpcClk(lpcBusClockPin), .accessReq(lpcAccessReq));
	// ----------------------------------------
	// Clock, watchdog and monitors
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (hostSwResetPulse === 1'b1) swSeen <= 1'b1;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	// Ready is looked at on the falling edge, where it already equals what the next rising edge samples
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, ta, tw, done;
		int k;
		{aw, w, done, k} = {3'h6, 32'h0};
		@(posedge clk_sys);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		while (!done && k < 100) begin
			@(negedge clk_sys);
			{ta, tw, done, rsp} = {aw & s_axi_awready, w & s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clk_sys);
			{aw, w} = {aw & ~ta, w & ~tw};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, !done};
			k++;
		end
		if (!done) fail_count++;
	endtask
	task automatic axr(input logic [7:0] a);
		logic ar, ta, done;
		int k;
		{ar, done, k} = {2'h2, 32'h0};
		@(posedge clk_sys);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		while (!done && k < 100) begin
			@(negedge clk_sys);
			{ta, done, rd, rsp} = {ar & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk_sys);
			ar = ar & ~ta;
			{s_axi_arvalid, s_axi_rready} <= {ar, !done};
			k++;
		end
		if (!done) fail_count++;
	endtask
	task automatic wait_core(input logic lvl, output int n);
		n = 0;
		while (coreResetN !== lvl && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 200) fail_count++;
	endtask
	// Watchdog when wd is 1, debugger command otherwise; a host frame is started into the reset
	task automatic soft_reset(input logic wd, input logic [31:0] expPortC);
		int n;
		axw(`RCDC_CTRL_OFS, 32'h0000_0091);
		chk(clockGenSel, 32'h9);
		{watchdogReq, debugResetReq, frameReq} <= {wd, !wd, 1'b1};
		wait_core(1'b0, n);
		repeat (3) @(posedge clk_sys);
		{watchdogReq, debugResetReq} <= 2'h0;
		@(negedge clk_sys);
		chk(lpcSync, 32'h6);
		chk(lpcSyncValid, 32'h1);
		chk(keyboardHostResetOut, 32'h1);
		chk(tapResetN, 32'h1);
		chk(wakeCtrlResetN, 32'h0);
		chk(portCBitZeroResetN, expPortC);
		wait_core(1'b1, n);
		chk(n + 4 >= IRST, 32'h1);
		chk(clockGenSel, 32'h4);
		repeat (3) @(negedge clk_sys);
		chk(lpcSync, 32'h0);
		chk(lpcClockSeen, 32'h1);
		@(posedge clk_sys);
		frameReq <= 1'b0;
		axr(`RCDC_STRAP_OFS);
		chk(rd, 32'h5);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{resetn, retainGood, clocksStable, watchdogReq, debugResetReq, frameReq, flashR2Select} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{supplyPorN, primaryResetN, secondaryResetPinA, secondaryResetPinB, hostPowerOn, flashR2Enable} = '1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		strapIn = 3'h5;
		repeat (8) @(negedge clk_sys);
		chk(strapPullDown, 32'h7);
		chk(retainedResetN, 32'h0);
		@(posedge clk_sys);
		{resetn, retainGood, clocksStable} <= 3'h7;
		wait_core(1'b1, c);
		chk(c >= IRST, 32'h1);
		chk(xtalEnable, 32'h1);
		chk(clockGenSel, 32'h4);
		chk(strapPullDown, 32'h0);
		axr(`RCDC_STRAP_OFS);
		chk(rd, 32'h5);
		axr(`RCDC_CTRL_OFS);
		chk(rd, `RCDC_CTRL_RESET);
		axr(8'h40);
		chk(rsp, 32'h2);
		chk(rd, 32'h0);
		strapIn <= 3'h2;
		$display("Test power-up done");
		soft_reset(1'b1, 32'h0);
		$display("Test watchdog done");
		soft_reset(1'b0, 32'h1);
		$display("Test debugger done");
		axw(`RCDC_HSIO_OFS, 32'h0000_0080);
		axw(`RCDC_HSIO_OFS, 32'h0000_0082);
		chk(rsp, 32'h0);
		axr(`RCDC_HSIO_OFS);
		chk(rd, 32'h80);
		chk(swSeen, 32'h1);
		$display("Test software reset done");
		primaryResetN <= 1'b0;
		wait_core(1'b0, c);
		chk(busFloat & busCtrlDeassert & coreAbort, 32'h1);
		repeat (10) @(negedge clk_sys);
		chk({coreResetN, coreActiveMode}, 32'h3);
		chk({hostHwResetN, lpcEngineIdle}, 32'h1);
		@(posedge clk_sys);
		primaryResetN <= 1'b1;
		repeat (5) @(negedge clk_sys);
		chk(hostHwResetN, 32'h1);
		axr(`RCDC_HSIO_OFS);
		chk(rd, 32'h0);
		axr(`RCDC_STRAP_OFS);
		chk(rd, 32'h5);
		$display("Test warm reset done");
		secondaryResetPinA <= 1'b0;
		repeat (5) @(negedge clk_sys);
		chk({hostHwResetN, secondaryResetIrq}, 32'h1);
		@(posedge clk_sys);
		secondaryResetPinA <= 1'b1;
		flashR2Select <= 1'b1;
		{secondaryResetPinB, retainGood} <= 2'h0;
		repeat (4) @(negedge clk_sys);
		chk({hostHwResetN, secondaryResetIrq}, 32'h1);
		chk(retainedResetN, 32'h0);
		@(posedge clk_sys);
		{hostPowerOn, retainGood} <= 2'h1;
		repeat (4) @(negedge clk_sys);
		chk({hostHwResetN, secondaryResetIrq}, 32'h3);
		chk(retainedResetN, 32'h1);
		@(posedge clk_sys);
		{hostPowerOn, secondaryResetPinB} <= 2'h3;
		$display("Test secondary reset done");
		{supplyPorN, primaryResetN} <= 2'h0;
		repeat (5) @(negedge clk_sys);
		chk({tapResetN, portCBitZeroResetN, wakeCtrlResetN, strapOut, strapOe}, 32'h0);
		@(posedge clk_sys);
		{supplyPorN, primaryResetN} <= 2'h3;
		wait_core(1'b1, c);
		chk(c >= IRST, 32'h1);
		chk(clockGenSel, 32'h4);
		axr(`RCDC_CAUSE_OFS);
		chk(rd, `RCDC_CAUSE_POR);
		axr(`RCDC_STRAP_OFS);
		chk(rd, 32'h2);
		axr(`RCDC_CTRL_OFS);
		chk(rd, `RCDC_CTRL_RESET);
		$display("Test power-up over warm done");
		print_verdict();
	end
endmodule
`default_nettype wire
